// ===== rtl/wwss_defines.svh
// offsets, field positions, reset values and timing counts of the supervisor
`ifndef WWSS_DEFINES_SVH
`define WWSS_DEFINES_SVH
`define WWSS_OFF_WDCTL      8'h00
`define WWSS_OFF_WAKE       8'h04
`define WWSS_OFF_MODE       8'h08
`define WWSS_OFF_STAT       8'h0c
`define WWSS_WAKE_EN_A      0
`define WWSS_WAKE_BUSWK     1
`define WWSS_WAKE_KEEPON    2
`define WWSS_WAKE_OVRST     3
`define WWSS_WAKE_RST       4'h2
`define WWSS_WDCTL_RST      8'h04
`define WWSS_CMD_NORMAL     2'h0
`define WWSS_CMD_STOP       2'h1
`define WWSS_CMD_SOFTRST    2'h3
`define WWSS_F_POR          0
`define WWSS_F_SERFAIL      1
`define WWSS_F_BATUV        2
`define WWSS_F_HSUV         3
`define WWSS_F_HSOV         4
`define WWSS_F_WARN         5
`define WWSS_F_MUV          6
`define WWSS_F_UVFS         7
`define WWSS_F_MOV          8
`define WWSS_F_WDFAIL       9
`define WWSS_NFLAGS         10
`define WWSS_CLOSED_PCT     14'd60
`define WWSS_OPEN_END_PCT   14'd140
`define WWSS_LONG_MS        11'd200
`define WWSS_UV_LIMIT       2'd3
`define WWSS_CLK_NS         100
`define WWSS_TICK_NS        1000000
`define WWSS_RESET_DELAY_NS 10000
`define WWSS_RESET_DELAY_CYC ((`WWSS_RESET_DELAY_NS + `WWSS_CLK_NS - 1) / `WWSS_CLK_NS)
`endif

// ===== rtl/wwss_pkg.sv
// types shared by the watchdog and supply supervisor
package wwss_pkg;
  typedef enum logic [2:0] {
    S_INIT     = 3'h0,
    S_NORMAL   = 3'h1,
    S_STOP     = 3'h3,
    S_RESTART  = 3'h2,
    S_FAILSAFE = 3'h6,
    S_OFF      = 3'h4
  } wwss_mode_t;

  typedef struct packed {
    logic       checksum;
    logic       stop_disable_enable_b;
    logic       window_mode;
    logic       fail_to_failsafe;
    logic       reserved;
    logic [2:0] watchdog_period_field;
  } wwss_wdctl_t;

  typedef struct packed {
    logic main_uv;
    logic main_warn;
    logic main_ov;
    logic main_rise_ok;
    logic bat_uv;
    logic bat_por_low;
    logic hs_uv;
    logic hs_ov;
    logic config_pin_level;
    logic can_wake;
    logic lin_wake;
  } wwss_supply_t;
endpackage

// ===== rtl/wwss_top.sv
// window watchdog and supply supervisor with an ahb-lite register slave
`timescale 1ns/1ns
`include "wwss_defines.svh"

// Summary of operation
// R01 - period is closed window then open window
// R02 - closed window is 60% of period
// R03 - host triggers between 0.72 and 1.20 periods
// R04 - good trigger restarts with closed window
// R05 - early trigger or expiry forces reset
// R06 - control write needs even parity bits 15..8
// R07 - bad parity discards write, sets flag
// R08 - parity includes written reserved bit
// R09 - host sets two enables to disable
// R10 - sequence error clears second enable
// R11 - stop trigger or normal re-enables watchdog
// R12 - restarting sequence clears first enable
// R13 - bus wake restarts disabled watchdog
// R14 - wake in stop raises interrupt, pulls receive low
// R15 - power-on sets flag, holds reset
// R16 - battery loss resets, restarts in init
// R17 - battery undervoltage flag, aux off
// R18 - highside flags, lin receive only
// R19 - prewarn flag; undervoltage forces restart
// R20 - fourth undervoltage enters fail-safe
// R21 - overvoltage with pin high restarts
// R22 - overvoltage with pin low fail-safe
// R23 - trigger is valid control write
// R24 - long open window of 200 ms
// R25 - seven selectable watchdog periods
// R26 - delays and comparators are parameters
module wwss_top
  import wwss_pkg::*;
#(
  parameter int TICK_CYC = `WWSS_TICK_NS / `WWSS_CLK_NS
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic      [31:0]  hrdata,
  output logic              hreadyout,
  output logic              hresp,
  input  wire wwss_supply_t supply_in,
  output logic              reset_out_n,
  output logic              fail_outputs,
  output logic              aux_reg_en,
  output logic              main_sc_prot_en,
  output logic              lin_rx_only,
  output logic              wake_irq,
  output logic              can_rxd_low,
  output logic              lin_rxd_low
);
  wwss_supply_t     s1_r, sp_r, sp_d_r;
  wwss_mode_t       mode_r, mode_nxt;
  wwss_wdctl_t      ctl_r;
  logic             en_a_r, bus_wake_en_r, keep_on_r, ovrst_en_r;
  logic [`WWSS_NFLAGS-1:0] flag_r, flag_nxt, flag_set, flag_clr;
  logic             wr_pend_r;
  logic [7:0]       addr_r;
  logic [1:0]       uv_cnt_r;
  logic [15:0]      dly_cnt_r, tick_cnt_r;
  logic [10:0]      ms_cnt_r, per_ms, lim_ms, closed_ms;
  logic             wd_on_r, long_r;
  logic [7:0]       wd_byte;
  logic             par_ok, wr_ctrl, trig, closed_hit, expire, wd_fail_ev;
  logic             active, uv_ev, uv_count_en, uv_fourth, ov_ev, wake_ev;
  logic             soft_rst, regs_default, stop_entry, stop_disable, from_stop;
  logic             wd_restart, dly_done;
  logic [1:0]       cmd;

  // two-stage synchroniser, then an edge history stage
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s1_r   <= '0;
      sp_r   <= '0;
      sp_d_r <= '0;
    end else begin
      s1_r   <= supply_in;
      sp_r   <= s1_r;
      sp_d_r <= sp_r;
    end
  end

  // ahb-lite slave, zero wait states, always okay
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wr_pend_r <= 1'b0;
      addr_r    <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend_r <= hsel && htrans[1] && hready && hwrite && (hsize == 3'h2) &&
                   (haddr[31:8] == 24'h0);
      addr_r    <= haddr[7:0];
      if (hsel && htrans[1] && hready && !hwrite) begin
        if (haddr[31:8] != 24'h0) begin
          hrdata <= 32'h0000_0000;
        end else if (haddr[7:0] == `WWSS_OFF_WDCTL) begin
          // reserved bit reads back as zero
          hrdata <= {16'h0000, ctl_r[7:5], ctl_r[4], 1'b0, ctl_r[2:0], 8'h00};
        end else if (haddr[7:0] == `WWSS_OFF_WAKE) begin
          hrdata <= {28'h0, ovrst_en_r, keep_on_r, bus_wake_en_r, en_a_r};
        end else if (haddr[7:0] == `WWSS_OFF_MODE) begin
          hrdata <= {21'h0, wd_on_r, long_r, uv_cnt_r, 4'h0, mode_r};
        end else if (haddr[7:0] == `WWSS_OFF_STAT) begin
          hrdata <= {22'h0, flag_r};
        end else begin
          hrdata <= 32'h0000_0000;
        end
      end
    end
  end

  // R06 parity check over the written byte
  // R08 reserved bit counts as written
  assign wd_byte  = hwdata[15:8];
  assign par_ok   = ~^wd_byte;
  assign wr_ctrl  = wr_pend_r && (addr_r == `WWSS_OFF_WDCTL);
  assign cmd      = hwdata[1:0];
  assign active   = (mode_r == S_INIT) || (mode_r == S_NORMAL) || (mode_r == S_STOP);
  assign soft_rst = wr_pend_r && (addr_r == `WWSS_OFF_MODE) && (cmd == `WWSS_CMD_SOFTRST) &&
                    ((mode_r == S_NORMAL) || (mode_r == S_STOP));
  // R16 battery loss reloads defaults
  assign regs_default = soft_rst || sp_r.bat_por_low;

  // R25 period lookup
  always_comb begin
    case (ctl_r.watchdog_period_field)
      3'h2:    per_ms = 11'd20;
      3'h3:    per_ms = 11'd50;
      3'h4:    per_ms = 11'd100;
      3'h5:    per_ms = 11'd200;
      3'h6:    per_ms = 11'd500;
      3'h7:    per_ms = 11'd1000;
      default: per_ms = 11'd10;
    endcase
  end

  // R02 closed window 60%, open window centred on the period
  assign closed_ms = 11'(({7'h00, per_ms} * `WWSS_CLOSED_PCT) / 18'd100);
  // R24 long open window limit
  assign lim_ms    = long_r ? `WWSS_LONG_MS :
                     ctl_r.window_mode ? 11'(({7'h00, per_ms} * `WWSS_OPEN_END_PCT) / 18'd100) :
                     per_ms;

  // R23 a valid control write is the trigger
  assign trig       = wr_ctrl && par_ok && ((mode_r == S_NORMAL) || (mode_r == S_STOP));
  // R01 trigger inside closed window is a failure
  assign closed_hit = trig && wd_on_r && ctl_r.window_mode && !long_r && (ms_cnt_r < closed_ms);
  assign expire     = wd_on_r && (ms_cnt_r >= lim_ms);
  // R05 watchdog failure event
  assign wd_fail_ev = ((mode_r == S_NORMAL) || (mode_r == S_STOP)) && (closed_hit || expire);

  assign uv_ev       = active && sp_r.main_uv && !sp_d_r.main_uv;
  // R20 count paused in normal during battery undervoltage
  assign uv_count_en = uv_ev && !((mode_r == S_NORMAL) && sp_r.bat_uv);
  assign uv_fourth   = uv_count_en && (uv_cnt_r == `WWSS_UV_LIMIT);
  assign ov_ev       = active && sp_r.main_ov && !sp_d_r.main_ov;
  assign wake_ev     = (sp_r.can_wake && !sp_d_r.can_wake) || (sp_r.lin_wake && !sp_d_r.lin_wake);
  assign stop_entry  = (mode_r == S_NORMAL) && (mode_nxt == S_STOP);
  assign stop_disable = stop_entry && en_a_r && ctl_r.stop_disable_enable_b;
  assign from_stop   = (mode_r == S_STOP) && (mode_nxt == S_NORMAL);
  assign dly_done    = dly_cnt_r >= 16'(`WWSS_RESET_DELAY_CYC);

  // mode sequencing
  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      S_OFF: begin
        mode_nxt = S_INIT;
      end
      S_INIT, S_RESTART: begin
        if (dly_done) begin
          mode_nxt = S_NORMAL;
        end
      end
      S_FAILSAFE: begin
        if (wake_ev) begin
          mode_nxt = S_RESTART;
        end
      end
      S_NORMAL, S_STOP: begin
        if (wr_pend_r && (addr_r == `WWSS_OFF_MODE)) begin
          if (cmd == `WWSS_CMD_SOFTRST) begin
            mode_nxt = S_INIT;
          end else if (cmd == `WWSS_CMD_STOP) begin
            mode_nxt = S_STOP;
          end else if (cmd == `WWSS_CMD_NORMAL) begin
            mode_nxt = S_NORMAL;
          end
        end
      end
      default: begin
        mode_nxt = S_OFF;
      end
    endcase
    if (active) begin
      // R20 fourth undervoltage
      if (uv_fourth) begin
        mode_nxt = S_FAILSAFE;
      // R19 undervoltage restart
      end else if (uv_ev) begin
        mode_nxt = S_RESTART;
      // R21 R22 overvoltage by pin level
      end else if (ov_ev && ovrst_en_r) begin
        mode_nxt = sp_r.config_pin_level ? S_RESTART : S_FAILSAFE;
      // R05 restart or fail-safe as configured
      end else if (wd_fail_ev) begin
        mode_nxt = ctl_r.fail_to_failsafe ? S_FAILSAFE : S_RESTART;
      end
    end
    // R16 battery below power-on threshold
    if (sp_r.bat_por_low) begin
      mode_nxt = S_OFF;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mode_r <= S_OFF;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // R15 R26 reset delay counted once the regulator is up
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dly_cnt_r <= 16'h0000;
    end else if (mode_nxt != mode_r) begin
      dly_cnt_r <= 16'h0000;
    end else if (((mode_r == S_INIT) && sp_r.main_rise_ok && !sp_r.main_uv) ||
                 ((mode_r == S_RESTART) && !sp_r.main_uv)) begin
      if (!dly_done) begin
        dly_cnt_r <= dly_cnt_r + 16'h0001;
      end
    end
  end

  // watchdog timer
  assign wd_restart = trig || from_stop ||
                      ((mode_r == S_STOP) && !wd_on_r && wake_ev && bus_wake_en_r);
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wd_on_r    <= 1'b1;
      long_r     <= 1'b1;
      ms_cnt_r   <= 11'h000;
      tick_cnt_r <= 16'h0000;
    end else if ((mode_r != S_NORMAL) && (mode_r != S_STOP)) begin
      // R24 start with long open window
      wd_on_r    <= 1'b1;
      long_r     <= 1'b1;
      ms_cnt_r   <= 11'h000;
      tick_cnt_r <= 16'h0000;
    end else if (wd_restart && !closed_hit) begin
      // R04 R11 R13 restart the period
      wd_on_r    <= 1'b1;
      long_r     <= !wd_on_r || from_stop;
      ms_cnt_r   <= 11'h000;
      tick_cnt_r <= 16'h0000;
    end else if (stop_disable) begin
      wd_on_r    <= 1'b0;
    end else if (wd_on_r) begin
      if (tick_cnt_r == 16'(TICK_CYC - 1)) begin
        tick_cnt_r <= 16'h0000;
        ms_cnt_r   <= ms_cnt_r + 11'h001;
      end else begin
        tick_cnt_r <= tick_cnt_r + 16'h0001;
      end
    end
  end

  // software-written configuration
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctl_r         <= wwss_wdctl_t'(`WWSS_WDCTL_RST);
      en_a_r        <= 1'((`WWSS_WAKE_RST >> `WWSS_WAKE_EN_A) & 4'h1);
      bus_wake_en_r <= 1'b1;
      keep_on_r     <= 1'b0;
      ovrst_en_r    <= 1'b0;
    end else if (regs_default) begin
      ctl_r         <= wwss_wdctl_t'(`WWSS_WDCTL_RST);
      en_a_r        <= 1'b0;
      bus_wake_en_r <= 1'b1;
      keep_on_r     <= 1'b0;
      ovrst_en_r    <= 1'b0;
    end else begin
      // R07 settings change only on good parity
      if (wr_ctrl && par_ok && (mode_r == S_NORMAL)) begin
        ctl_r          <= wwss_wdctl_t'(wd_byte);
        ctl_r.reserved <= 1'b0;
        // R10 second enable without the first is an error
        ctl_r.stop_disable_enable_b <= wd_byte[6] && en_a_r;
      end
      if (wr_pend_r && (addr_r == `WWSS_OFF_WAKE) && (mode_r == S_NORMAL)) begin
        keep_on_r  <= hwdata[`WWSS_WAKE_KEEPON];
        ovrst_en_r <= hwdata[`WWSS_WAKE_OVRST];
        // R13 bus wake enable fixed once the sequence runs
        if (!en_a_r) begin
          bus_wake_en_r <= hwdata[`WWSS_WAKE_BUSWK];
        end
        // R12 restart of sequence clears first enable
        if (hwdata[`WWSS_WAKE_EN_A]) begin
          en_a_r <= !en_a_r;
        end
      end
      // R10 incomplete sequence at stop entry
      if (stop_entry && !(en_a_r && ctl_r.stop_disable_enable_b)) begin
        ctl_r.stop_disable_enable_b <= 1'b0;
      end
      // R11 re-enable clears both enables
      if (((mode_r == S_STOP) && !wd_on_r && trig) || from_stop) begin
        en_a_r                      <= 1'b0;
        ctl_r.stop_disable_enable_b <= 1'b0;
      end
      // R21 overvoltage reset bit clears itself
      if (active && ov_ev && ovrst_en_r && sp_r.config_pin_level) begin
        ovrst_en_r <= 1'b0;
      end
    end
  end

  // status flags: write one to clear, set wins
  always_comb begin
    flag_set = '0;
    flag_clr = '0;
    if (wr_pend_r && (addr_r == `WWSS_OFF_STAT)) begin
      flag_clr = hwdata[`WWSS_NFLAGS-1:0];
    end
    // R18 R17 condition-held flags clear only after it ends
    flag_clr[`WWSS_F_BATUV] = flag_clr[`WWSS_F_BATUV] && !sp_r.bat_uv;
    flag_clr[`WWSS_F_HSUV]  = flag_clr[`WWSS_F_HSUV] && !sp_r.hs_uv;
    flag_clr[`WWSS_F_HSOV]  = flag_clr[`WWSS_F_HSOV] && !sp_r.hs_ov;
    // R15 power-on flag
    flag_set[`WWSS_F_POR]     = sp_r.bat_por_low;
    // R07 serial failure flag
    flag_set[`WWSS_F_SERFAIL] = wr_ctrl && !par_ok;
    flag_set[`WWSS_F_BATUV]   = sp_r.bat_uv;
    flag_set[`WWSS_F_HSUV]    = sp_r.hs_uv;
    flag_set[`WWSS_F_HSOV]    = sp_r.hs_ov;
    // R19 prewarning and undervoltage flags
    flag_set[`WWSS_F_WARN]    = active && sp_r.main_warn;
    flag_set[`WWSS_F_MUV]     = uv_ev;
    flag_set[`WWSS_F_UVFS]    = uv_fourth;
    // R21 overvoltage flag set in init, normal or stop, with or without reset enable
    flag_set[`WWSS_F_MOV]     = ov_ev;
    flag_set[`WWSS_F_WDFAIL]  = wd_fail_ev;
    flag_nxt = (flag_r & ~flag_clr) | flag_set;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      flag_r <= `WWSS_NFLAGS'(1);
    end else if (soft_rst) begin
      flag_r <= '0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  // R20 undervoltage counter and its clears
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      uv_cnt_r <= 2'h0;
    end else if (regs_default || (mode_nxt == S_FAILSAFE) ||
                 (flag_r[`WWSS_F_MUV] && !flag_nxt[`WWSS_F_MUV])) begin
      uv_cnt_r <= 2'h0;
    end else if (uv_count_en) begin
      uv_cnt_r <= uv_cnt_r + 2'h1;
    end
  end

  // pin outputs
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reset_out_n     <= 1'b0;
      fail_outputs    <= 1'b0;
      aux_reg_en      <= 1'b0;
      main_sc_prot_en <= 1'b0;
      lin_rx_only     <= 1'b0;
    end else begin
      // R15 R19 reset held outside normal and stop
      reset_out_n     <= (mode_nxt == S_NORMAL) || (mode_nxt == S_STOP);
      // R17 aux regulator and short-circuit guard
      aux_reg_en      <= !sp_r.bat_uv || keep_on_r;
      main_sc_prot_en <= !sp_r.bat_uv;
      // R18 receive only on highside undervoltage
      lin_rx_only     <= sp_r.hs_uv;
      // R21 R22 fail outputs on fail-safe or overvoltage restart
      if (regs_default) begin
        fail_outputs <= 1'b0;
      end else if ((mode_nxt == S_FAILSAFE) || (ov_ev && ovrst_en_r)) begin
        fail_outputs <= 1'b1;
      end
    end
  end

  // R14 wake indication in stop, held until stop mode is left
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wake_irq    <= 1'b0;
      can_rxd_low <= 1'b0;
      lin_rxd_low <= 1'b0;
    end else if (wake_ev && (mode_r == S_STOP)) begin
      wake_irq    <= 1'b1;
      can_rxd_low <= can_rxd_low || (sp_r.can_wake && !sp_d_r.can_wake);
      lin_rxd_low <= lin_rxd_low || (sp_r.lin_wake && !sp_d_r.lin_wake);
    end else if (mode_r != S_STOP) begin
      wake_irq    <= 1'b0;
      can_rxd_low <= 1'b0;
      lin_rxd_low <= 1'b0;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence seq_fail_mode;
    (mode_r == S_RESTART) || (mode_r == S_FAILSAFE);
  endsequence
  sequence seq_reset_low;
    !reset_out_n;
  endsequence

  a_parity_discard: assert property (wr_ctrl && !par_ok |=> flag_r[`WWSS_F_SERFAIL] && $stable(ctl_r)) // R07
    else $error("bad parity write was not discarded");
  a_closed_trigger: assert property (closed_hit && !uv_ev && !sp_r.bat_por_low |=> seq_fail_mode ##0 seq_reset_low) // R05
    else $error("closed window trigger did not reset");
  a_good_restart: assert property (trig && wd_on_r && !closed_hit && mode_r == S_NORMAL && mode_nxt == S_NORMAL |=> ms_cnt_r == 11'h000 && !long_r) // R04
    else $error("good trigger did not restart the period");
  a_uv_fourth: assert property (uv_fourth && !sp_r.bat_por_low |=> mode_r == S_FAILSAFE && flag_r[`WWSS_F_UVFS] && uv_cnt_r == 2'h0) // R20
    else $error("fourth undervoltage did not enter fail-safe");
  a_uv_restart: assert property (uv_ev && !uv_fourth && !sp_r.bat_por_low |=> mode_r == S_RESTART && flag_r[`WWSS_F_MUV] && !reset_out_n) // R19
    else $error("undervoltage did not force restart");
  a_ov_pin: assert property (ov_ev && ovrst_en_r && !uv_ev && !sp_r.bat_por_low |=> (mode_r == (sp_r.config_pin_level ? S_RESTART : S_FAILSAFE)) ##0 fail_outputs) // R22
    else $error("overvoltage mode does not follow pin");
  a_ov_autoclr: assert property (active && ov_ev && ovrst_en_r && sp_r.config_pin_level && !regs_default |=> !ovrst_en_r && flag_r[`WWSS_F_MOV]) // R21
    else $error("overvoltage reset bit not cleared");
  a_init_hold: assert property (mode_r == S_INIT |-> !reset_out_n) // R15
    else $error("reset released during init");
  a_bus_wake: assert property (mode_r == S_STOP && !wd_on_r && wake_ev && bus_wake_en_r && mode_nxt == S_STOP |=> wd_on_r && long_r ##1 wake_irq) // R13
    else $error("bus wake did not restart watchdog");
  a_seq_error: assert property (wr_ctrl && par_ok && mode_r == S_NORMAL && !en_a_r && !regs_default |=> !ctl_r.stop_disable_enable_b) // R10
    else $error("second enable set out of sequence");
  a_hs_rx_only: assert property ($rose(sp_r.hs_uv) |=> lin_rx_only && flag_r[`WWSS_F_HSUV]) // R18
    else $error("highside undervoltage not handled");
endmodule // wwss_top

// ===== tb/wwss_host_model.sv
// host model: ahb-lite master that serves the supervisor
`timescale 1ns/1ns
module wwss_host_model (
  input  wire logic        ref_clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  function automatic logic [7:0] wd_byte(input logic [6:0] v);
    return {^v, v};
  endfunction
  // one whole word, held until hready
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic ok);
    int n;
    ok = 1'b1;
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hwdata <= ~hwdata;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) ok = 1'b0;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) ok = 1'b0;
    q = hrdata;
  endtask
endmodule // wwss_host_model

// ===== tb/wwss_top_test.sv
// self-checking bench of the watchdog and supply supervisor
`timescale 1ns/1ns
module wwss_top_test;
  import wwss_pkg::*;
  logic ref_clk, rst, hsel, hwrite, hready, hresp;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic reset_out_n, fail_outputs, aux_reg_en, main_sc_prot_en, lin_rx_only;
  logic wake_irq, can_rxd_low, lin_rxd_low;
  wwss_supply_t sup;
  int bad_count, n_tests, n;
  wwss_host_model host (.ref_clk(ref_clk), .hready(hready), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  wwss_top #(.TICK_CYC(10)) uut (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .supply_in(sup),
    .reset_out_n(reset_out_n), .fail_outputs(fail_outputs), .aux_reg_en(aux_reg_en),
    .main_sc_prot_en(main_sc_prot_en), .lin_rx_only(lin_rx_only), .wake_irq(wake_irq),
    .can_rxd_low(can_rxd_low), .lin_rxd_low(lin_rxd_low));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      bad_count++;
    end
  endtask
  task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
    logic ok;
    host.xfer(wr, a, d, q, ok);
    if (!ok) begin
      bad_count++;
      report_and_stop();
    end
  endtask
  task automatic wd(input logic [6:0] v);
    acc(1'b1, 8'h00, {16'h0, host.wd_byte(v), 8'h00});
  endtask
  // bounded wait for the reset output to reach a level
  task automatic wait_ro(input logic lvl, input int lim);
    n = 0;
    while (reset_out_n !== lvl && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
    if (reset_out_n !== lvl) begin
      bad_count++;
      report_and_stop();
    end
  endtask
  initial begin
    rst = 1'b1;
    sup = '0;
    sup.main_rise_ok = 1'b1;
    bad_count = 0;
    n_tests = 0;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    wait_ro(1'b1, 200);
    chk(n >= 100, 1);
    acc(0, 8'h0c, 0);
    chk(q, 32'h1);
    acc(1, 8'h0c, 32'h1);
    acc(0, 8'h04, 0);
    chk(q, 32'h2);
    acc(0, 8'h40, 0);
    chk(q, 32'h0);
    wd(7'h0f);
    acc(0, 8'h00, 0);
    chk(q, 32'h0700);
    acc(1, 8'h00, 32'h0700);
    acc(0, 8'h00, 0);
    chk(q, 32'h0700);
    acc(0, 8'h0c, 0);
    chk(q, 32'h2);
    acc(1, 8'h0c, 32'h2);
    // service at 0.8 of a 100-cycle period
    wd(7'h21);
    repeat (80) @(posedge ref_clk);
    wd(7'h21);
    repeat (80) @(posedge ref_clk);
    wd(7'h21);
    chk(reset_out_n, 1);
    repeat (20) @(posedge ref_clk);
    wd(7'h21);
    wait_ro(1'b0, 10);
    acc(0, 8'h0c, 0);
    chk(q & 32'h200, 32'h200);
    wait_ro(1'b1, 150);
    acc(0, 8'h08, 0);
    chk(q & 32'h7, 32'h1);
    wait_ro(1'b0, 2100);
    chk(n >= 1990, 1);
    wait_ro(1'b1, 150);
    acc(1, 8'h0c, 32'h3ff);
    wd(7'h07);
    acc(1, 8'h04, 32'h3);
    wd(7'h47);
    acc(1, 8'h08, 32'h1);
    acc(0, 8'h08, 0);
    chk(q & 32'h407, 32'h003);
    sup.can_wake <= 1'b1;
    repeat (6) @(posedge ref_clk);
    chk({wake_irq, can_rxd_low, lin_rxd_low}, 3'b110);
    acc(0, 8'h08, 0);
    chk(q & 32'h607, 32'h603);
    sup.can_wake <= 1'b0;
    acc(1, 8'h08, 32'h0);
    repeat (3) @(posedge ref_clk);
    chk(wake_irq, 0);
    acc(0, 8'h04, 0);
    chk(q & 32'h1, 32'h0);
    acc(0, 8'h00, 0);
    chk(q & 32'h4000, 32'h0);
    sup.hs_uv <= 1'b1;
    sup.bat_uv <= 1'b1;
    repeat (6) @(posedge ref_clk);
    chk({lin_rx_only, aux_reg_en, main_sc_prot_en}, 3'b100);
    acc(1, 8'h0c, 32'hc);
    acc(0, 8'h0c, 0);
    chk(q & 32'hc, 32'hc);
    sup.hs_uv <= 1'b0;
    sup.bat_uv <= 1'b0;
    repeat (6) @(posedge ref_clk);
    acc(1, 8'h0c, 32'hc);
    acc(0, 8'h0c, 0);
    chk(q & 32'hc, 32'h0);
    chk({aux_reg_en, main_sc_prot_en}, 2'b11);
    sup.main_uv <= 1'b1;
    wait_ro(1'b0, 10);
    acc(0, 8'h0c, 0);
    chk(q & 32'h40, 32'h40);
    sup.main_uv <= 1'b0;
    wait_ro(1'b1, 150);
    chk(hresp, 0);
    acc(1, 8'h04, 32'ha);
    sup.config_pin_level <= 1'b1;
    sup.main_ov <= 1'b1;
    wait_ro(1'b0, 10);
    chk(fail_outputs, 1);
    acc(0, 8'h04, 0);
    chk(q, 32'h2);
    acc(0, 8'h0c, 0);
    chk(q & 32'h100, 32'h100);
    wait_ro(1'b1, 150);
    sup.main_ov <= 1'b0;
    acc(1, 8'h08, 32'h3);
    wait_ro(1'b0, 10);
    wait_ro(1'b1, 150);
    chk(fail_outputs, 0);
    wd(7'h44);
    acc(0, 8'h00, 0);
    chk(q & 32'h4000, 32'h0);
    acc(1, 8'h04, 32'h3);
    acc(1, 8'h04, 32'h3);
    acc(0, 8'h04, 0);
    chk(q, 32'h2);
    repeat (3) begin
      sup.main_uv <= 1'b1;
      wait_ro(1'b0, 10);
      sup.main_uv <= 1'b0;
      wait_ro(1'b1, 150);
    end
    sup.main_uv <= 1'b1;
    wait_ro(1'b0, 10);
    acc(0, 8'h08, 0);
    chk(q & 32'h187, 32'h006);
    chk(fail_outputs, 1);
    acc(0, 8'h0c, 0);
    chk(q & 32'h80, 32'h80);
    sup.main_uv <= 1'b0;
    sup.bat_por_low <= 1'b1;
    repeat (6) @(posedge ref_clk);
    chk(fail_outputs, 0);
    acc(0, 8'h08, 0);
    chk(q & 32'h7, 32'h4);
    sup.bat_por_low <= 1'b0;
    wait_ro(1'b1, 150);
    acc(0, 8'h0c, 0);
    chk(q & 32'h1, 32'h1);
    report_and_stop();
  end
endmodule // wwss_top_test
